// ### flash_irq_pkg.sv
// Constants for the flash controller interrupt block
// Overview of operation
// (RL1) Request changes only on the bus clock
// (RL2) Request is a level, active high
// (RL3) Request high while any masked bit set
// (RL4) Writing one to clear register drops pending
// (RL5) Completed write or erase raises done
// (RL6) Aborted row write raises timeout
// (RL7) Row write ready for word raises next
// (RL8) Each source owns one shared bit position
// (RL9) Software reads each pending bit individually
// (RL10) Enable-set write one enables, zero ignored
// (RL11) Enable-clear write one disables, zero ignored
// (RL12) Status-set write one makes source pending
// (RL13) Unserviced next-word request ends in timeout
// (RL14) Masked bit is pending AND enable
// (RL15) Pending and enable bits reset to zero
package flash_irq_pkg;
    // Number of interrupt sources
    localparam int SRC_W = 3;
    // Bus address width in bits
    localparam int ADR_W = 8;
    // Register byte offsets
    localparam logic [7:0] OFF_ENABLE_SET = 8'h00;
    localparam logic [7:0] OFF_ENABLE_CLEAR = 8'h04;
    localparam logic [7:0] OFF_PENDING_SET = 8'h08;
    localparam logic [7:0] OFF_PENDING_CLEAR = 8'h0C;
    localparam logic [7:0] OFF_MASKED_STATUS = 8'h10;
    // Source bit positions, shared by all five registers
    localparam int BIT_DONE = 0;
    localparam int BIT_TIMEOUT = 1;
    localparam int BIT_NEXT_WORD = 2;
    // Values after reset
    localparam logic [2:0] PENDING_RST = 3'h0;
    localparam logic [2:0] ENABLE_RST = 3'h0;
    localparam logic [31:0] DATA_RST = 32'h00000000;
endpackage

// ### flash_irq_ctrl.sv
// Interrupt pending, enable and request logic with a classic Wishbone slave
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
module flash_irq_ctrl
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic done_pulse_i,
    input wire logic timeout_pulse_i,
    input wire logic next_word_pulse_i,
    output logic irq_o
);

    // Word-aligned address match, used by every decoder
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction

    // Raw pending bits
    logic [2:0] pending_ff;
    // Per-source enables
    logic [2:0] enable_ff;
    // Registered bus answer
    logic ack_ff;
    logic [31:0] rdata_ff;
    // Registered request line
    logic irq_ff;
    // Next values
    logic [2:0] nxt_pending;
    logic [2:0] nxt_enable;
    logic [31:0] nxt_rdata;

    // Bus request present
    wire req = cyc_i & stb_i;
    // Write commits at the edge where the master sees ack
    wire wr_commit = req & we_i & ack_ff & sel_i[0];
    // Address decode
    wire sel_en_set = hit(adr_i, flash_irq_pkg::OFF_ENABLE_SET);
    wire sel_en_clr = hit(adr_i, flash_irq_pkg::OFF_ENABLE_CLEAR);
    wire sel_pd_set = hit(adr_i, flash_irq_pkg::OFF_PENDING_SET);
    wire sel_pd_clr = hit(adr_i, flash_irq_pkg::OFF_PENDING_CLEAR);
    wire sel_masked = hit(adr_i, flash_irq_pkg::OFF_MASKED_STATUS);
    // Write strobes per register
    wire wr_en_set = wr_commit & sel_en_set;
    wire wr_en_clr = wr_commit & sel_en_clr;
    wire wr_pd_set = wr_commit & sel_pd_set;
    wire wr_pd_clr = wr_commit & sel_pd_clr;
    wire [2:0] wbits = dat_i[2:0];

    // Hardware events, one bit per source
    wire [2:0] hw_event;
    assign hw_event[flash_irq_pkg::BIT_DONE] = done_pulse_i; // RL5 RL8
    assign hw_event[flash_irq_pkg::BIT_TIMEOUT] = timeout_pulse_i; // RL6 RL13
    assign hw_event[flash_irq_pkg::BIT_NEXT_WORD] = next_word_pulse_i; // RL7

    // Set wins over clear, so an event in the clearing cycle is kept
    assign nxt_pending = (pending_ff & ~({3{wr_pd_clr}} & wbits)) // RL4
        | ({3{wr_pd_set}} & wbits) // RL12
        | hw_event;
    // Zeros in the write data leave enables alone
    assign nxt_enable = (enable_ff & ~({3{wr_en_clr}} & wbits)) // RL11
        | ({3{wr_en_set}} & wbits); // RL10

    // Masked view of pending sources
    wire [2:0] masked = pending_ff & enable_ff; // RL14

    // Read mux; enable and pending each show from two offsets
    assign nxt_rdata = (sel_en_set | sel_en_clr) ? {29'h0, enable_ff} // RL10 RL11
        : (sel_pd_set | sel_pd_clr) ? {29'h0, pending_ff} // RL9 RL12
        : sel_masked ? {29'h0, masked} // RL14
        : flash_irq_pkg::DATA_RST;

    // Interrupt state; cleared by reset so the request starts low
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pending_ff <= flash_irq_pkg::PENDING_RST; // RL15
            enable_ff <= flash_irq_pkg::ENABLE_RST; // RL15
        end
        else
        begin
            pending_ff <= nxt_pending;
            enable_ff <= nxt_enable;
        end
    end

    // Request follows next-state so it tracks pending without extra lag
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(nxt_pending & nxt_enable); // RL1 RL2 RL3
    end

    // Bus answer: ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
            rdata_ff <= flash_irq_pkg::DATA_RST;
        end
        else
        begin
            ack_ff <= req & ~ack_ff;
            // Unmapped offsets answer with zero data
            rdata_ff <= (req & ~ack_ff & ~we_i) ? nxt_rdata : flash_irq_pkg::DATA_RST;
        end
    end

    assign ack_o = ack_ff;
    assign dat_o = rdata_ff;
    assign irq_o = irq_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Single commit cycle of a bus write as seen by the slave, for a chosen register group
    sequence wr_seen(logic s);
        s && wr_commit;
    endsequence

    irq_level_a: assert property (irq_o == |(pending_ff & enable_ff)) // RL3
        else $error("request does not match masked status");
    irq_rest_a: assert property ((!irq_o && !(|masked)) [*2] |=> !irq_o || $changed(masked)) // RL2
        else $error("request pulsed without a cause");
    clear_drop_a: assert property (wr_seen(sel_pd_clr) |=> (pending_ff & $past(wbits) & ~$past(hw_event)) == 3'h0) // RL4
        else $error("pending clear write did not drop bit");
    done_set_a: assert property (done_pulse_i |=> pending_ff[0]) // RL5
        else $error("done event not recorded");
    timeout_set_a: assert property (timeout_pulse_i |=> pending_ff[1]) // RL6
        else $error("timeout event not recorded");
    next_set_a: assert property (next_word_pulse_i |=> pending_ff[2]) // RL7
        else $error("next word event not recorded");
    enable_set_a: assert property (wr_seen(sel_en_set) |=> (enable_ff & $past(wbits)) == $past(wbits)) // RL10
        else $error("enable set write lost");
    enable_clr_a: assert property (wr_seen(sel_en_clr) |=> (enable_ff & $past(wbits)) == 3'h0) // RL11
        else $error("enable clear write lost");
    pend_set_a: assert property (wr_seen(sel_pd_set) |=> (pending_ff & $past(wbits)) == $past(wbits)) // RL12
        else $error("pending set write lost");
    masked_read_a: assert property (req && !we_i && !ack_ff && sel_masked |=> ack_o && dat_o == {29'h0, $past(masked)}) // RL14
        else $error("masked status read wrong");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    reset_clear_a: assert property (@(posedge clk_i) $past(rst_i) |-> pending_ff == 3'h0 && enable_ff == 3'h0 && !irq_o) // RL15
        else $error("state not cleared by reset");

    // Read request first seen by the slave, for a chosen register group
    sequence rd_taken(logic s);
        req && !we_i && !ack_ff && s;
    endsequence

    // Request may only rise with a masked cause behind it
    irq_rise_a: assert property ( // RL3
        $rose(irq_o)
        |-> |masked)
        else $error("request rose without masked cause");

    // Request may only fall once every masked cause is gone
    irq_fall_a: assert property ( // RL3
        $fell(irq_o)
        |-> masked == 3'h0)
        else $error("request fell with masked cause left");

    // A level, not a pulse: steady cause gives a steady request
    irq_steady_a: assert property ( // RL2
        $stable(masked)
        |-> $stable(irq_o))
        else $error("request moved while cause was steady");

    // Request moves only on the bus clock, together with its cause
    irq_clocked_a: assert property ( // RL1
        $changed(irq_o)
        |-> $changed(masked))
        else $error("request changed without its cause");

    // Pending bits hold when nothing sets or clears them
    pend_hold_a: assert property ( // RL9
        hw_event == 3'h0 && !wr_pd_set && !wr_pd_clr
        |=> $stable(pending_ff))
        else $error("pending bits moved on their own");

    // Enables hold when no enable write commits
    enable_hold_a: assert property ( // RL10 RL11
        !wr_en_set && !wr_en_clr
        |=> $stable(enable_ff))
        else $error("enable bits moved on their own");

    // Event in the clearing cycle must survive the clear
    set_wins_a: assert property ( // RL4
        wr_seen(sel_pd_clr && hw_event != 3'h0)
        |=> (pending_ff & $past(hw_event)) == $past(hw_event))
        else $error("event lost against a clear write");

    // Zeros written to enable-set leave those bits alone
    en_set_keep_a: assert property ( // RL10
        wr_seen(sel_en_set)
        |=> (enable_ff & ~$past(wbits)) == ($past(enable_ff) & ~$past(wbits)))
        else $error("enable set write disturbed other bits");

    // Zeros written to enable-clear leave those bits alone
    en_clr_keep_a: assert property ( // RL11
        wr_seen(sel_en_clr)
        |=> (enable_ff & ~$past(wbits)) == ($past(enable_ff) & ~$past(wbits)))
        else $error("enable clear write disturbed other bits");

    // Zeros written to pending-set leave those bits alone
    pd_set_keep_a: assert property ( // RL12
        wr_seen(sel_pd_set && hw_event == 3'h0)
        |=> (pending_ff & ~$past(wbits)) == ($past(pending_ff) & ~$past(wbits)))
        else $error("pending set write disturbed other bits");

    // Clear write with no event drops exactly the written ones
    pd_clr_keep_a: assert property ( // RL4
        wr_seen(sel_pd_clr && hw_event == 3'h0)
        |=> pending_ff == ($past(pending_ff) & ~$past(wbits)))
        else $error("pending clear write gave wrong bits");

    // Set write with no event adds exactly the written ones
    pd_set_exact_a: assert property ( // RL12
        wr_seen(sel_pd_set && hw_event == 3'h0)
        |=> pending_ff == ($past(pending_ff) | $past(wbits)))
        else $error("pending set write gave wrong bits");

    // Enable-set write result in full
    en_set_exact_a: assert property ( // RL10
        wr_seen(sel_en_set)
        |=> enable_ff == ($past(enable_ff) | $past(wbits)))
        else $error("enable set write gave wrong bits");

    // Enable-clear write result in full
    en_clr_exact_a: assert property ( // RL11
        wr_seen(sel_en_clr)
        |=> enable_ff == ($past(enable_ff) & ~$past(wbits)))
        else $error("enable clear write gave wrong bits");

    // Every new request is answered in the next cycle
    ack_answer_a: assert property ( // RL9
        req && !ack_o
        |=> ack_o)
        else $error("request not answered in one cycle");

    // Ack only follows a request that was not already acked
    ack_cause_a: assert property ( // RL9
        ack_o
        |-> $past(req) && !$past(ack_o))
        else $error("ack without a fresh request");

    // Read data is zero outside the ack cycle
    data_idle_a: assert property ( // RL9
        !ack_o
        |-> dat_o == flash_irq_pkg::DATA_RST)
        else $error("read data present without ack");

    // Bits above the three sources always read zero
    data_upper_a: assert property ( // RL8
        ack_o
        |-> dat_o[31:3] == 29'h0)
        else $error("unused read bits not zero");

    // Either enable offset reads back the enables
    enable_read_a: assert property ( // RL10 RL11
        rd_taken(sel_en_set || sel_en_clr)
        |=> ack_o && dat_o == {29'h0, $past(enable_ff)})
        else $error("enable read wrong");

    // Either pending offset reads back the raw pending bits
    pending_read_a: assert property ( // RL9 RL12
        rd_taken(sel_pd_set || sel_pd_clr)
        |=> ack_o && dat_o == {29'h0, $past(pending_ff)})
        else $error("pending read wrong");

    // Offsets outside the map answer with zero
    unmapped_read_a: assert property ( // RL8
        rd_taken(!(sel_en_set || sel_en_clr || sel_pd_set || sel_pd_clr || sel_masked))
        |=> ack_o && dat_o == flash_irq_pkg::DATA_RST)
        else $error("unmapped read not zero");

    // Writes are acked with zero data
    write_data_a: assert property ( // RL9
        req && we_i && !ack_o
        |=> ack_o && dat_o == flash_irq_pkg::DATA_RST)
        else $error("write answer carried data");

    // Done bit only rises from its event or a software set
    done_cause_a: assert property ( // RL5 RL8
        $rose(pending_ff[flash_irq_pkg::BIT_DONE])
        |-> $past(done_pulse_i) || $past(wr_pd_set && wbits[flash_irq_pkg::BIT_DONE]))
        else $error("done bit rose without cause");

    // Timeout bit only rises from its event or a software set
    timeout_cause_a: assert property ( // RL6 RL13
        $rose(pending_ff[flash_irq_pkg::BIT_TIMEOUT])
        |-> $past(timeout_pulse_i) || $past(wr_pd_set && wbits[flash_irq_pkg::BIT_TIMEOUT]))
        else $error("timeout bit rose without cause");

    // Next-word bit only rises from its event or a software set
    next_cause_a: assert property ( // RL7
        $rose(pending_ff[flash_irq_pkg::BIT_NEXT_WORD])
        |-> $past(next_word_pulse_i) || $past(wr_pd_set && wbits[flash_irq_pkg::BIT_NEXT_WORD]))
        else $error("next word bit rose without cause");

    // A pending bit only falls through a clear write
    pend_fall_a: assert property ( // RL4
        $changed(pending_ff)
        |-> (($past(pending_ff) & ~pending_ff) & ~$past({3{wr_pd_clr}} & wbits)) == 3'h0)
        else $error("pending bit fell without clear");

    // A pending bit only rises through an event or set write
    pend_rise_a: assert property ( // RL12
        $changed(pending_ff)
        |-> ((pending_ff & ~$past(pending_ff)) & ~$past(({3{wr_pd_set}} & wbits) | hw_event)) == 3'h0)
        else $error("pending bit rose without cause");

    // An enable only falls through an enable-clear write
    en_fall_a: assert property ( // RL11
        $changed(enable_ff)
        |-> (($past(enable_ff) & ~enable_ff) & ~$past({3{wr_en_clr}} & wbits)) == 3'h0)
        else $error("enable fell without clear");

    // An enable only rises through an enable-set write
    en_rise_a: assert property ( // RL10
        $changed(enable_ff)
        |-> ((enable_ff & ~$past(enable_ff)) & ~$past({3{wr_en_set}} & wbits)) == 3'h0)
        else $error("enable rose without set");

    // Writes without the low byte lane change nothing
    no_lane_write_a: assert property ( // RL8
        req && we_i && ack_ff && !sel_i[0] && hw_event == 3'h0
        |=> $stable(pending_ff) && $stable(enable_ff))
        else $error("write without low lane took effect");

endmodule

// ### cpu_irq_sink.sv
// Model of the processor's level interrupt input
`timescale 1ns/1ns
module cpu_irq_sink
(
    input wire logic clk_i,
    input wire logic irq_i,
    output logic taken_o
);
    // Level input sampled on the bus clock, never edge detected
    always_ff @(posedge clk_i)
    begin
        taken_o <= irq_i;
    end
endmodule

// ### test_flash_irq_ctrl.sv
// Self-checking bench for the flash interrupt block
`timescale 1ns/1ns
module test_flash_irq_ctrl;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ack_o, irq_o, taken;
    logic [2:0] ev = 3'h0; // Event pulses: next, timeout, done
    int miscompares = 0, samples_checked = 0;
    flash_irq_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .dat_i(dat_i), .sel_i(4'hF), .dat_o(dat_o), .ack_o(ack_o), .done_pulse_i(ev[0]),
        .timeout_pulse_i(ev[1]), .next_word_pulse_i(ev[2]), .irq_o(irq_o));
    cpu_irq_sink sink_u (.clk_i(clk_i), .irq_i(irq_o), .taken_o(taken));
    // Free running 8 ns clock
    initial
    begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One classic cycle; held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        // A missing answer counts against the run
        if (n >= 20)
            miscompares++;
        rd = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0;
        @(negedge clk_i);
    endtask
    // All five offsets read zero after reset, request low
    task automatic t_reset;
        for (int i = 0; i < 5; i++)
        begin
            wb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, 32'h00000000);
        end
        chk(irq_o, 1'b0);
    endtask
    // Enable set and clear: ones act, zeros are ignored
    task automatic t_enable;
        wb(1'b1, 8'h00, 32'h00000005);
        wb(1'b1, 8'h04, 32'h00000000);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h00000005);
        wb(1'b1, 8'h04, 32'h00000001);
        wb(1'b1, 8'h00, 32'h00000000);
        wb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h00000004);
    endtask
    // Each source in its own bit; only next word is enabled now
    task automatic t_events;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk_i);
            ev <= 3'(1 << i);
            @(posedge clk_i);
            ev <= 3'h0;
            wb(1'b0, 8'h08, 32'h0);
            chk(rd, 32'(1 << i));
            wb(1'b0, 8'h10, 32'h0);
            chk(rd, 32'((1 << i) & 4));
            chk(irq_o, 1'(i == 2));
            chk(taken, 1'(i == 2));
            wb(1'b1, 8'h0C, 32'(1 << i));
            wb(1'b0, 8'h0C, 32'h0);
            chk(rd, 32'h00000000);
        end
    endtask
    // Software set, unmapped read, partial clear keeps the level
    task automatic t_swset;
        wb(1'b1, 8'h08, 32'h00000003);
        wb(1'b1, 8'h00, 32'h00000003);
        chk(irq_o, 1'b1);
        wb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h00000000);
        wb(1'b1, 8'h0C, 32'h00000001);
        chk(irq_o, 1'b1);
        wb(1'b1, 8'h0C, 32'h00000002);
        chk(irq_o, 1'b0);
    endtask
    task automatic test_done;
        if (miscompares == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Main sequence after a 12 cycle reset
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_enable;
        t_events;
        t_swset;
        test_done;
    end
    // Watchdog far beyond the hundred or so cycles needed
    initial
    begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        test_done;
    end
endmodule
